/* include/spb_pkg.sv */
// Purpose: Shared constants for the synchronous peripheral bus adapter.
// Assumes: Link clock is the processor input clock; ref_clk is the user side.
// Notes:   Bus states are counted in half link clocks.
package spb_pkg;
  // ==========================================================================
  // Phase clock
  localparam int E_DIV = 10;
  localparam int E_LOW_CLKS = 6;
  localparam logic [3:0] E_LAST = 4'h9;
  localparam logic [3:0] E_RISE = 4'h6;
  // ==========================================================================
  // Function codes and vectors
  localparam logic [2:0] FC_IACK = 3'h7;
  localparam logic [7:0] AUTOVEC_BASE = 8'h18;
  // ==========================================================================
  // Peripheral end window
  localparam logic [23:1] PER_BASE = 23'h7f0000;
  localparam logic [23:1] PER_MASK = 23'h7ffff0;
  localparam int PER_WORDS = 16;
  // ==========================================================================
  // Device end bus states
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_S0 = 7'h02,
    ST_S2 = 7'h04,
    ST_S4 = 7'h08,
    ST_SYNC = 7'h10,
    ST_XFER = 7'h20,
    ST_END = 7'h40
  } spb_state_e;
endpackage : spb_pkg

/* include/spb_if.sv */
// Purpose: Pins between the processor end and the synchronous peripherals.
// Assumes: Two-way pins carry an active-low output enable per driver.
// Notes:   The shared data bus is resolved here from the enables.
interface spb_if (
  input wire logic link_clk
);
  logic [23:1] addr;
  logic addr_oe_n;
  logic [2:0] fc;
  logic addr_strobe_n;
  logic uds_n;
  logic lds_n;
  logic rw;
  logic e;
  logic valid_mem_qualifier_n;
  logic sync_periph_select_in;
  logic transfer_ack_in;
  logic [15:0] dev_dout;
  logic dev_doe_n;
  logic [15:0] per_dout;
  logic per_doe_n;
  logic [15:0] data;

  // ==========================================================================
  // Bus resolution
  // An undriven bus reads as all ones, like a pulled-up bus.
  assign data = !dev_doe_n ? dev_dout :
                !per_doe_n ? per_dout : 16'hffff;

  modport dev (
    input link_clk, sync_periph_select_in, transfer_ack_in, data,
    output addr, addr_oe_n, fc, addr_strobe_n, uds_n, lds_n, rw, e,
    output valid_mem_qualifier_n, dev_dout, dev_doe_n
  );
  modport per (
    input link_clk, addr, addr_oe_n, fc, addr_strobe_n, uds_n, lds_n, rw,
    input e, valid_mem_qualifier_n, data,
    output sync_periph_select_in, transfer_ack_in, per_dout, per_doe_n
  );
endinterface : spb_if

/* design/spb_dev_end.sv */
// Purpose: Processor end: runs synchronous peripheral cycles on request.
// Assumes: User holds request fields stable from req_valid until rsp_valid.
// Notes:   Link logic runs on both edges of the link clock (half states).
// Function
// R1: Phase clock is input clock over ten, 6/4.
// R2: Phase clock allows back-to-back peripheral accesses.
// R3: State zero: address floats, function code driven.
// R4: State one: address outputs start driving.
// R5: State two: address strobe, read byte strobes.
// R6: Write: direction low S2, data S3, strobes S4.
// R7: Wait states until select input is recognized.
// R8: Decode drives select from address and strobe.
// R9: Peripheral chip select uses qualifier and address.
// R10: After select, wait phase low, assert qualifier.
// R11: Peripheral transfers while phase clock high.
// R12: Early select recognized at falling edge of S4.
// R13: Recognition three to two clocks before rise.
// R14: Read data captured in state six.
// R15: S7 strobes negate with phase fall; address floats.
// R16: Write end: data floats, direction returns high.
// R17: Select removed within one clock after strobe.
// R18: Asynchronous acknowledge never asserted with select.
// R19: Qualifier is active low.
// R20: Vector fetch with select uses autovector 25-31.
// R21: Decode avoids peripheral access during autovectoring.
// R22: Phase clock divider runs continuously.
module spb_dev_end
  import spb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_iack,
  input wire logic [2:0] req_level,
  input wire logic [2:0] req_fc,
  input wire logic [23:1] req_addr,
  input wire logic req_uds,
  input wire logic req_lds,
  input wire logic [15:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  output logic rsp_autovec,
  output logic [7:0] rsp_vector,
  spb_if.dev bus
);
  // ==========================================================================
  // User side
  logic req_tog_reg;
  logic done_s1_reg;
  logic done_s2_reg;
  logic done_seen_reg;
  logic done_tog_reg;
  logic [15:0] rdata_reg;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      req_tog_reg <= 1'b0;
      req_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
      rsp_autovec <= 1'b0;
      rsp_vector <= 8'h00;
      done_s1_reg <= 1'b0;
      done_s2_reg <= 1'b0;
      done_seen_reg <= 1'b0;
    end else if (clk_en) begin
      done_s1_reg <= done_tog_reg;
      done_s2_reg <= done_s1_reg;
      rsp_valid <= 1'b0;
      if (req_valid && req_ready) begin
        req_tog_reg <= ~req_tog_reg;
        req_ready <= 1'b0;
      end
      if (done_s2_reg != done_seen_reg) begin
        done_seen_reg <= done_s2_reg;
        req_ready <= 1'b1;
        rsp_valid <= 1'b1;
        rsp_rdata <= rdata_reg;
        rsp_autovec <= req_iack;
        rsp_vector <= AUTOVEC_BASE + {5'h00, req_level}; // see R20
      end
    end
  end

  // ==========================================================================
  // Link side crossings
  // The enable is a level from the user domain, so it is synchronised too.
  logic ce_s1_reg;
  logic ce_s2_reg;
  logic req_s1_reg;
  logic req_s2_reg;
  logic req_seen_reg;

  always_ff @(posedge bus.link_clk or negedge resetn) begin
    if (!resetn) begin
      ce_s1_reg <= 1'b0;
      ce_s2_reg <= 1'b0;
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
    end else begin
      ce_s1_reg <= clk_en;
      ce_s2_reg <= ce_s1_reg;
      if (ce_s2_reg) begin
        req_s1_reg <= req_tog_reg;
        req_s2_reg <= req_s1_reg;
      end
    end
  end

  // ==========================================================================
  // Phase clock divider
  // It never stops for bus activity, so every wait is measured against it.
  logic [3:0] e_cnt_reg;

  always_ff @(posedge bus.link_clk or negedge resetn) begin
    if (!resetn) begin
      e_cnt_reg <= 4'h0;
      bus.e <= 1'b0;
    end else if (ce_s2_reg) begin
      e_cnt_reg <= (e_cnt_reg == E_LAST) ? 4'h0 : e_cnt_reg + 4'h1; // see R22
      bus.e <= (e_cnt_reg >= E_RISE - 4'h1) && (e_cnt_reg != E_LAST); // see R1
    end
  end

  // ==========================================================================
  // Select input, sampled on falling edges
  logic vpa_s1_reg;
  logic vpa_s2_reg;

  always_ff @(negedge bus.link_clk or negedge resetn) begin
    if (!resetn) begin
      vpa_s1_reg <= 1'b0;
      vpa_s2_reg <= 1'b0;
    end else if (ce_s2_reg) begin
      vpa_s1_reg <= bus.sync_periph_select_in;
      vpa_s2_reg <= vpa_s1_reg; // see R12
    end
  end

  // ==========================================================================
  // Bus cycle sequencer
  spb_state_e state_reg;
  logic wr_reg;

  always_ff @(posedge bus.link_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      req_seen_reg <= 1'b0;
      done_tog_reg <= 1'b0;
      wr_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      bus.addr <= 23'h000000;
      bus.fc <= 3'h0;
      bus.addr_strobe_n <= 1'b1;
      bus.uds_n <= 1'b1;
      bus.lds_n <= 1'b1;
      bus.rw <= 1'b1;
      bus.valid_mem_qualifier_n <= 1'b1;
      bus.dev_dout <= 16'h0000;
    end else if (ce_s2_reg) begin
      case (state_reg)
        ST_IDLE: begin
          if (req_s2_reg != req_seen_reg) begin
            req_seen_reg <= req_s2_reg;
            wr_reg <= req_write && !req_iack;
            bus.fc <= req_iack ? FC_IACK : req_fc; // see R3
            bus.addr <= req_iack ? {20'h7ffff, req_level} : req_addr;
            bus.dev_dout <= req_wdata;
            state_reg <= ST_S0;
          end
        end
        ST_S0: begin
          bus.addr_strobe_n <= 1'b0; // see R5
          if (wr_reg) begin
            bus.rw <= 1'b0; // see R6
          end else begin
            bus.uds_n <= !(req_uds || req_iack);
            bus.lds_n <= !(req_lds || req_iack);
          end
          state_reg <= ST_S2;
        end
        ST_S2: begin
          if (wr_reg) begin
            bus.uds_n <= !req_uds; // see R6
            bus.lds_n <= !req_lds;
          end
          state_reg <= ST_S4;
        end
        ST_S4: begin
          // Asynchronous acknowledge is not honoured on this path.
          if (vpa_s2_reg) begin
            state_reg <= ST_SYNC; // see R7
          end
        end
        ST_SYNC: begin
          // Qualifier only goes low while E is low and not about to rise.
          if (!bus.e && e_cnt_reg < E_RISE - 4'h1) begin
            bus.valid_mem_qualifier_n <= 1'b0; // see R10 see R19 see R13
            state_reg <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (e_cnt_reg == E_LAST) begin
            rdata_reg <= bus.data; // see R14 see R11
            bus.addr_strobe_n <= 1'b1; // see R15
            bus.uds_n <= 1'b1;
            bus.lds_n <= 1'b1;
            bus.valid_mem_qualifier_n <= 1'b1;
            state_reg <= ST_END;
          end
        end
        ST_END: begin
          bus.rw <= 1'b1; // see R16
          done_tog_reg <= ~done_tog_reg;
          state_reg <= ST_IDLE; // see R2
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Half-clock drivers
  // Taken on the falling edge so they trail the state change by half a clock.
  always_ff @(negedge bus.link_clk or negedge resetn) begin
    if (!resetn) begin
      bus.addr_oe_n <= 1'b1;
      bus.dev_doe_n <= 1'b1;
    end else if (ce_s2_reg) begin
      bus.addr_oe_n <= (state_reg == ST_IDLE) || (state_reg == ST_END); // see R4
      bus.dev_doe_n <= !(wr_reg && (state_reg == ST_S2 ||
                         state_reg == ST_S4 || state_reg == ST_SYNC ||
                         state_reg == ST_XFER)); // see R6 see R16
    end
  end
endmodule : spb_dev_end

/* design/spb_per_end.sv */
// Purpose: Address decode plus a small synchronous peripheral.
// Assumes: Bus pins come from logic on the same link clock.
// Notes:   Holds PER_WORDS words; writes are reported to the user side.
module spb_per_end
  import spb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  output logic wr_pulse,
  output logic [3:0] wr_index,
  output logic [15:0] wr_word,
  spb_if.per bus
);
  // ==========================================================================
  // Enable crossing and decode
  logic ce_s1_reg;
  logic ce_s2_reg;
  logic hit;
  logic cs;
  logic [15:0] mem [PER_WORDS];
  logic wr_hit_reg;
  logic wr_tog_reg;
  logic [3:0] idx_reg;
  logic [15:0] word_reg;

  assign hit = (bus.addr & PER_MASK) == PER_BASE;
  // The qualifier gates the chip select; vector fetches never select it.
  assign cs = hit && !bus.valid_mem_qualifier_n &&
              !bus.addr_oe_n && (bus.fc != FC_IACK); // see R9 see R21

  always_ff @(posedge bus.link_clk or negedge resetn) begin
    if (!resetn) begin
      ce_s1_reg <= 1'b0;
      ce_s2_reg <= 1'b0;
    end else begin
      ce_s1_reg <= clk_en;
      ce_s2_reg <= ce_s1_reg;
    end
  end

  // ==========================================================================
  // Select and acknowledge
  // Select drops the first clock after the strobe goes high.
  always_ff @(posedge bus.link_clk or negedge resetn) begin
    if (!resetn) begin
      bus.sync_periph_select_in <= 1'b0;
      bus.transfer_ack_in <= 1'b0;
    end else if (ce_s2_reg) begin
      bus.sync_periph_select_in <= !bus.addr_strobe_n && !bus.addr_oe_n &&
                                   (hit || bus.fc == FC_IACK); // see R8 see R17
      bus.transfer_ack_in <= 1'b0; // see R18
    end
  end

  // ==========================================================================
  // Peripheral transfer during E high
  always_ff @(posedge bus.link_clk or negedge resetn) begin
    if (!resetn) begin
      wr_hit_reg <= 1'b0;
      bus.per_doe_n <= 1'b1;
      bus.per_dout <= 16'h0000;
      wr_tog_reg <= 1'b0;
      idx_reg <= 4'h0;
      word_reg <= 16'h0000;
    end else if (ce_s2_reg) begin
      // The qualifier lifts as E falls, so the write is caught while E is
      // high and only reported once E has fallen.
      wr_hit_reg <= cs && !bus.rw && bus.e;
      bus.per_doe_n <= !(cs && bus.rw && bus.e); // see R11
      bus.per_dout <= mem[bus.addr[4:1]];
      if (cs && !bus.rw && bus.e) begin
        idx_reg <= bus.addr[4:1];
        word_reg <= bus.data;
      end
      if (wr_hit_reg && !bus.e) begin
        wr_tog_reg <= ~wr_tog_reg; // see R11
      end
    end
  end

  // Storage has no reset; contents are undefined until written.
  always_ff @(posedge bus.link_clk) begin
    if (ce_s2_reg && cs && !bus.rw && bus.e && !bus.uds_n) begin
      mem[bus.addr[4:1]][15:8] <= bus.data[15:8];
    end
    if (ce_s2_reg && cs && !bus.rw && bus.e && !bus.lds_n) begin
      mem[bus.addr[4:1]][7:0] <= bus.data[7:0];
    end
  end

  // ==========================================================================
  // User side report
  logic t_s1_reg;
  logic t_s2_reg;
  logic t_seen_reg;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      t_s1_reg <= 1'b0;
      t_s2_reg <= 1'b0;
      t_seen_reg <= 1'b0;
      wr_pulse <= 1'b0;
      wr_index <= 4'h0;
      wr_word <= 16'h0000;
    end else if (clk_en) begin
      t_s1_reg <= wr_tog_reg;
      t_s2_reg <= t_s1_reg;
      wr_pulse <= t_s2_reg != t_seen_reg;
      if (t_s2_reg != t_seen_reg) begin
        t_seen_reg <= t_s2_reg;
        wr_index <= idx_reg;
        wr_word <= word_reg;
      end
    end
  end
endmodule : spb_per_end

/* tb/spb_properties.sv */
// Purpose: Link-side properties of the synchronous peripheral adapter.
// Assumes: All pins are sampled on the rising link clock.
// Notes:   Watches the interface pins as plain inputs.
module spb_properties (
  input wire logic link_clk,
  input wire logic resetn,
  input wire logic e,
  input wire logic addr_strobe_n,
  input wire logic uds_n,
  input wire logic rw,
  input wire logic addr_oe_n,
  input wire logic dev_doe_n,
  input wire logic valid_mem_qualifier_n,
  input wire logic sync_periph_select_in,
  input wire logic transfer_ack_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Phase clock shape
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!resetn);
  sequence e_high_run;
    e [*4] ##1 !e;
  endsequence
  sequence e_low_run;
    !e [*6] ##1 e;
  endsequence
  chk_e_high_four: assert property ($rose(e) |-> e_high_run)
    else $error("phase clock high time wrong");
  chk_e_low_six: assert property ($fell(e) |-> e_low_run)
    else $error("phase clock low time wrong");
  // ==========================================================================
  // Qualifier and strobes
  chk_qual_needs_strobe: assert property (
    !valid_mem_qualifier_n |-> !addr_strobe_n)
    else $error("qualifier low outside a cycle");
  chk_qual_after_sel: assert property (
    $fell(valid_mem_qualifier_n) |-> !e && $past(sync_periph_select_in)
    ##[1:7] $rose(e))
    else $error("qualifier not aligned to phase clock");
  chk_qual_over_high: assert property (
    $rose(e) && !valid_mem_qualifier_n |-> !valid_mem_qualifier_n [*4])
    else $error("qualifier dropped while phase clock high");
  chk_strobe_end: assert property (
    $rose(addr_strobe_n) |-> $fell(e) && $rose(valid_mem_qualifier_n))
    else $error("strobe end not with phase clock fall");
  chk_addr_driven: assert property (!addr_strobe_n |-> !addr_oe_n)
    else $error("address floats under strobe");
  chk_write_data: assert property (!uds_n && !rw |-> !dev_doe_n)
    else $error("write strobe without data");
  chk_write_end: assert property (
    $rose(rw) |-> dev_doe_n && addr_oe_n)
    else $error("buses not floated after cycle");
  chk_sel_release: assert property (
    $rose(addr_strobe_n) |-> ##[0:1] !sync_periph_select_in)
    else $error("select held too long");
  chk_no_ack: assert property (sync_periph_select_in |-> !transfer_ack_in)
    else $error("acknowledge with select");
endmodule : spb_properties

/* tb/sync_peripheral_bus_adapter_tb.sv */
// Purpose: Runs writes, reads and autovector fetches across the link.
// Assumes: Both ends meet in spb_if; clk_en held high on both.
// Notes:   Expected results are queued before each request.
module sync_peripheral_bus_adapter_tb
  import spb_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0, req_write = 1'b0, req_iack = 1'b0;
  logic [2:0] req_level = 3'h0, req_fc = 3'h0;
  logic [23:1] req_addr = 23'h0;
  logic req_uds = 1'b0, req_lds = 1'b0;
  logic [15:0] req_wdata = 16'h0;
  logic req_ready, rsp_valid, rsp_autovec, wr_pulse;
  logic [15:0] rsp_rdata, wr_word;
  logic [7:0] rsp_vector;
  logic [3:0] wr_index;
  logic [15:0] mem [16];
  logic [25:0] rq [$];
  logic [35:0] wq [$];
  int failures = 0, total_checks = 0;

  spb_if spb_if_inst (.link_clk(link_clk));
  spb_dev_end spb_dev_end_inst (.ref_clk(ref_clk), .resetn(resetn),
    .clk_en(1'b1), .req_valid(req_valid), .req_write(req_write),
    .req_iack(req_iack), .req_level(req_level), .req_fc(req_fc),
    .req_addr(req_addr), .req_uds(req_uds), .req_lds(req_lds),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_autovec(rsp_autovec),
    .rsp_vector(rsp_vector), .bus(spb_if_inst.dev));
  spb_per_end spb_per_end_inst (.ref_clk(ref_clk), .resetn(resetn),
    .clk_en(1'b1), .wr_pulse(wr_pulse), .wr_index(wr_index),
    .wr_word(wr_word), .bus(spb_if_inst.per));
  spb_properties spb_properties_inst (.link_clk(link_clk),
    .resetn(resetn), .e(spb_if_inst.e),
    .addr_strobe_n(spb_if_inst.addr_strobe_n), .uds_n(spb_if_inst.uds_n),
    .rw(spb_if_inst.rw), .addr_oe_n(spb_if_inst.addr_oe_n),
    .dev_doe_n(spb_if_inst.dev_doe_n),
    .valid_mem_qualifier_n(spb_if_inst.valid_mem_qualifier_n),
    .sync_periph_select_in(spb_if_inst.sync_periph_select_in),
    .transfer_ack_in(spb_if_inst.transfer_ack_in));

  // ==========================================================================
  // Clocks
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  // The odd offset keeps the link clock out of step with ref_clk.
  initial begin
    #17.3;
    forever #62.5 link_clk = ~link_clk;
  end

  // ==========================================================================
  // Checking and verdict
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    if (failures == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  // Responses are one-cycle pulses, so they are sampled mid-cycle.
  always @(negedge ref_clk) begin : mon
    logic [25:0] x;
    logic [35:0] w;
    if (rsp_valid === 1'b1 && rq.size() == 0) check(16'h1, 16'h0);
    else if (rsp_valid === 1'b1) begin
      x = rq.pop_front();
      check({15'h0, rsp_autovec}, {15'h0, x[8]});
      if (x[8]) check({8'h0, rsp_vector}, {8'h0, x[7:0]});
      if (x[25]) check(rsp_rdata, x[24:9]);
    end
    if (wr_pulse === 1'b1 && wq.size() == 0) check(16'h1, 16'h0);
    else if (wr_pulse === 1'b1) begin
      w = wq.pop_front();
      check({12'h0, wr_index}, {12'h0, w[19:16]});
      check(wr_word & w[35:20], w[15:0] & w[35:20]);
    end
  end

  // ==========================================================================
  // Request driver
  task automatic go(input logic wr, input logic ia, input logic [2:0] lv,
      input logic [2:0] f, input logic [23:1] a, input logic u,
      input logic l, input logic [15:0] d);
    int n;
    @(posedge ref_clk);
    req_write <= wr;
    req_iack <= ia;
    req_level <= lv;
    req_fc <= f;
    req_addr <= a;
    req_uds <= u;
    req_lds <= l;
    req_wdata <= d;
    req_valid <= 1'b1;
    n = 0;
    // The request is taken at the first edge that finds ready high, so
    // valid drops there; the fields stand until the answer.
    do begin
      @(negedge ref_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 3000);
    @(posedge ref_clk);
    req_valid <= 1'b0;
    @(negedge ref_clk);
    check({15'h0, req_ready}, 16'h0);
    do begin
      @(negedge ref_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      failures++;
      results();
    end
  endtask : go

  task automatic acc(input logic wr, input logic u, input logic l,
      input logic [3:0] ix, input logic [15:0] d);
    logic [15:0] m;
    m = {{8{u}}, {8{l}}};
    if (wr) begin
      mem[ix] = (mem[ix] & ~m) | (d & m);
      wq.push_back({m, ix, d});
      rq.push_back(26'h0);
    end else begin
      rq.push_back({1'b1, mem[ix], 9'h0});
    end
    go(wr, 1'b0, 3'h0, 3'h5, PER_BASE | 23'(ix), u, l, d);
  endtask : acc

  // ==========================================================================
  // Main sequence
  initial begin
    int i;
    logic [2:0] lv;
    void'($urandom(18916));
    repeat (2) @(posedge link_clk);
    @(posedge ref_clk);
    resetn <= 1'b1;
    for (i = 0; i < PER_WORDS; i++) acc(1'b1, 1'b1, 1'b1, 4'(i), 16'($urandom));
    acc(1'b1, 1'b1, 1'b0, 4'h3, 16'($urandom));
    acc(1'b1, 1'b0, 1'b1, 4'h5, 16'($urandom));
    for (i = PER_WORDS - 1; i >= 0; i--) acc(1'b0, 1'b1, 1'b1, 4'(i), 16'h0);
    for (i = 1; i < 8; i++) begin
      lv = 3'(i);
      rq.push_back({17'h0, 1'b1, AUTOVEC_BASE + 8'(lv)});
      go(1'b0, 1'b1, lv, FC_IACK, {20'h7ffff, lv}, 1'b1, 1'b1, 16'h0);
    end
    // Mixed traffic, each access with a random kind and word; writes also take a random lane set, reads use both lanes.
    for (i = 0; i < 24; i++) begin
      lv = 3'($urandom);
      acc(lv[0], lv[1] | ~lv[0], lv[2] | ~lv[0] | ~lv[1], 4'($urandom),
        16'($urandom));
    end
    repeat (20) @(posedge ref_clk);
    check(16'(rq.size() + wq.size()), 16'h0);
    results();
  end
endmodule : sync_peripheral_bus_adapter_tb
